// [verilog/cts_selector.sv]
// Conditional table selector: three tables, three conditions each, APB
// configuration, registered output copied from the selected lookup table.
// Assumes sources and lookup outputs are synchronous to pclk.
`timescale 1ns/1ps
module cts_selector
   import cts_pkg::*;
#(
   parameter int DW = DATA_W
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire cts_src_t [N_SRC-1:0] src_in,
   input  wire cts_lut_t [N_LUT-1:0] lut_in,
   output logic      [DW-1:0]     sel_out,
   output logic                   sel_valid,
   output logic      [1:0]        sel_table
);

   // ***************************************************************
   // Configuration state
   // ***************************************************************
   logic                enable_ff;
   logic [2:0]          tbl_op_ff  [N_TABLES];
   logic [3:0]          tbl_lut_ff [N_TABLES];
   cts_cond_cfg_t       cond_ff    [N_TABLES*N_CONDS];
   logic [1:0]          cond_res   [N_TABLES*N_CONDS];
   logic [N_TABLES-1:0] qualify;

   logic       access;
   logic [3:0] word;
   // Writes land only on the completing edge; misaligned ones are refused
   assign access = psel & penable & pready & clk_en & (paddr[1:0] == 2'h0);
   assign word   = paddr[5:2];

   // ***************************************************************
   // Condition evaluation
   // ***************************************************************
   for (genvar i = 0; i < N_TABLES*N_CONDS; i++) begin : g_cond
      // Block type and number together pick one source slot
      logic [SRC_NUM_W:0] idx1;
      logic [SRC_NUM_W:0] idx2;
      assign idx1 = {1'b0, cond_ff[i].arg1_type[1:0],
                     cond_ff[i].arg1_num[1:0]};
      assign idx2 = {1'b0, cond_ff[i].arg2_type[1:0],
                     cond_ff[i].arg2_num[1:0]};
      cts_cond_eval u_eval (
         .cfg    (cond_ff[i]),
         .arg1   (src_in[idx1[3:0]]),
         .arg2   (src_in[idx2[3:0]]),
         .result (cond_res[i])
      );
   end

   // ***************************************************************
   // Table qualification
   // ***************************************************************
   for (genvar t = 0; t < N_TABLES; t++) begin : g_tbl
      logic c1, c2, c3, n1, n2, n3;
      assign c1 = (cond_res[3*t]   == RES_TRUE);
      assign c2 = (cond_res[3*t+1] == RES_TRUE);
      assign c3 = (cond_res[3*t+2] == RES_TRUE);
      assign n1 = c1 | (cond_res[3*t]   == RES_NA);
      assign n2 = c2 | (cond_res[3*t+1] == RES_NA);
      assign n3 = c3 | (cond_res[3*t+2] == RES_NA);
      always_comb begin
         case (tbl_op_ff[t])
            LOG_DEFAULT: qualify[t] = 1'b1;
            LOG_AND3:    qualify[t] = n1 & n2 & n3;
            LOG_OR3:     qualify[t] = c1 | c2 | c3;
            LOG_AND_OR:  qualify[t] = (c1 & c2) | c3;
            LOG_OR_AND:  qualify[t] = (c1 | c2) & c3;
            default:     qualify[t] = 1'b0;
         endcase
      end
   end

   // ***************************************************************
   // Priority pick, combinational
   // ***************************************************************
   logic [1:0]    nxt_sel_table;
   cts_lut_t      pick;
   always_comb begin
      nxt_sel_table = SEL_NONE;
      pick          = '0;
      // Lowest number wins, so scan downward and overwrite
      for (int t = N_TABLES-1; t >= 0; t--) begin
         if (qualify[t]) begin
            nxt_sel_table = 2'(t + 1);
            pick          = lut_in[tbl_lut_ff[t]];
         end
      end
      if (!enable_ff) begin
         nxt_sel_table = SEL_NONE;
         pick          = '0;
      end
   end

   // ***************************************************************
   // Output registers, re-evaluated every enabled cycle
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_out   <= '0;
         sel_valid <= 1'b0;
         sel_table <= SEL_NONE;
      end else if (clk_en) begin
         sel_table <= nxt_sel_table;
         sel_valid <= pick.valid;
         sel_out   <= pick.valid ? pick.value : '0;
      end
   end

   // ***************************************************************
   // Register writes
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_ff <= 1'b0;
      end else if (access && pwrite && paddr == OFS_CTRL) begin
         enable_ff <= pwdata[CTRL_EN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tbl_op_ff[0]  <= RST_OP_T1;
         tbl_op_ff[1]  <= RST_OP_T2;
         tbl_op_ff[2]  <= RST_OP_T3;
         tbl_lut_ff[0] <= RST_LUT_T1;
         tbl_lut_ff[1] <= RST_LUT_T2;
         tbl_lut_ff[2] <= RST_LUT_T3;
      end else if (access && pwrite && paddr[11:4] == OFS_TBL_CFG[11:4]
                   && paddr[3:2] != 2'h3) begin
         tbl_op_ff[paddr[3:2]] <= pwdata[TBL_OP_LSB +: 3];
         // Numbers beyond the ten tables are refused
         if (pwdata[TBL_LUT_LSB +: 4] < 4'(N_LUT)) begin
            tbl_lut_ff[paddr[3:2]] <= pwdata[TBL_LUT_LSB +: 4];
         end
      end
   end

   // Condition word index from the byte address
   logic [11:0] cond_rel;
   logic [3:0]  cond_idx;
   logic        cond_hit;
   assign cond_rel = paddr - OFS_COND;
   assign cond_idx = cond_rel[5:2];
   assign cond_hit = (paddr >= OFS_COND) && (cond_rel[11:2] < 10'd9);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < N_TABLES*N_CONDS; i++) begin
            cond_ff[i] <= '{SRC_NOT_USED, '0, SRC_NOT_USED, '0,
                            REL_EQ};
         end
      end else if (access && pwrite && cond_hit) begin
         cond_ff[cond_idx].arg1_type <= pwdata[COND_A1T_LSB +: 4];
         cond_ff[cond_idx].arg1_num  <= pwdata[COND_A1N_LSB +: 4];
         cond_ff[cond_idx].arg2_type <= pwdata[COND_A2T_LSB +: 4];
         cond_ff[cond_idx].arg2_num  <= pwdata[COND_A2N_LSB +: 4];
         // Operator takes the written code only when both new sources are used, else REL_EQ
         if (pwdata[COND_A1T_LSB +: 4] != SRC_NOT_USED &&
             pwdata[COND_A2T_LSB +: 4] != SRC_NOT_USED) begin
            cond_ff[cond_idx].rel_op <= pwdata[COND_OP_LSB +: 3];
         end else begin
            cond_ff[cond_idx].rel_op <= REL_EQ;
         end
      end
   end

   // ***************************************************************
   // Register reads, APB with one wait state
   // ***************************************************************
   logic [31:0] rd;
   logic        bad;
   always_comb begin
      rd  = '0;
      bad = 1'b0;
      if (paddr == OFS_CTRL) begin
         rd[CTRL_EN_BIT] = enable_ff;
      end else if (paddr == OFS_STATUS) begin
         rd[STAT_SEL_LSB +: 2] = sel_table;
         rd[STAT_VAL_BIT]      = sel_valid;
      end else if (paddr[11:4] == OFS_TBL_CFG[11:4] && paddr[3:2] != 2'h3) begin
         rd[TBL_OP_LSB +: 3]  = tbl_op_ff[paddr[3:2]];
         rd[TBL_LUT_LSB +: 4] = tbl_lut_ff[paddr[3:2]];
      end else if (cond_hit) begin
         rd[COND_A1T_LSB +: 4] = cond_ff[cond_idx].arg1_type;
         rd[COND_A1N_LSB +: 4] = cond_ff[cond_idx].arg1_num;
         rd[COND_A2T_LSB +: 4] = cond_ff[cond_idx].arg2_type;
         rd[COND_A2N_LSB +: 4] = cond_ff[cond_idx].arg2_num;
         rd[COND_OP_LSB +: 3]  = cond_ff[cond_idx].rel_op;
         rd[COND_RES_LSB +: 2] = cond_res[cond_idx];
      end else if (paddr == OFS_OUT) begin
         rd[DW-1:0]      = sel_out;
         rd[OUT_VAL_BIT] = sel_valid;
      end else begin
         bad = 1'b1;
      end
      if (paddr[1:0] != 2'h0) begin
         bad = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         // Ready in the second access cycle, one bus wait state
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & bad;
         prdata  <= (psel & ~pwrite & ~bad) ? rd : '0;
      end
   end

endmodule

// [include/cts_pkg.sv]
// Package for the conditional table selector: register map, field codes,
// reset values and carrier types.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package cts_pkg;

   // ***************************************************************
   // Sizes
   // ***************************************************************
   localparam int N_TABLES      = 3;
   localparam int N_CONDS       = 3;
   localparam int N_LUT         = 10;
   localparam int DATA_W        = 16;
   localparam int SRC_TYPE_W    = 4;
   localparam int SRC_NUM_W     = 4;
   localparam int N_SRC         = 16;

   // ***************************************************************
   // Register offsets (byte addresses)
   // ***************************************************************
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_TBL_CFG  = 12'h010; // + 4*table
   localparam logic [11:0] OFS_COND     = 12'h020; // + 4*(3*table+cond)
   localparam logic [11:0] OFS_OUT      = 12'h050;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CTRL_EN_BIT      = 0;
   localparam int TBL_OP_LSB       = 0;   // 3 bits combining operator
   localparam int TBL_LUT_LSB      = 4;   // 4 bits lookup table number
   localparam int COND_A1T_LSB     = 0;
   localparam int COND_A1N_LSB     = 4;
   localparam int COND_A2T_LSB     = 8;
   localparam int COND_A2N_LSB     = 12;
   localparam int COND_OP_LSB      = 16;  // 3 bits relational operator
   localparam int COND_RES_LSB     = 20;  // 2 bits result, read only
   localparam int STAT_SEL_LSB     = 0;   // 2 bits selected table
   localparam int STAT_VAL_BIT     = 2;
   localparam int OUT_VAL_BIT      = 16;

   // ***************************************************************
   // Codes
   // ***************************************************************
   localparam logic [SRC_TYPE_W-1:0] SRC_NOT_USED = 4'h0;

   localparam logic [2:0] REL_EQ = 3'h0;
   localparam logic [2:0] REL_NE = 3'h1;
   localparam logic [2:0] REL_GT = 3'h2;
   localparam logic [2:0] REL_GE = 3'h3;
   localparam logic [2:0] REL_LT = 3'h4;
   localparam logic [2:0] REL_LE = 3'h5;

   localparam logic [1:0] RES_FALSE = 2'h0;
   localparam logic [1:0] RES_TRUE  = 2'h1;
   localparam logic [1:0] RES_ERROR = 2'h2;
   localparam logic [1:0] RES_NA    = 2'h3;

   localparam logic [2:0] LOG_DEFAULT = 3'h0;
   localparam logic [2:0] LOG_AND3    = 3'h1;
   localparam logic [2:0] LOG_OR3     = 3'h2;
   localparam logic [2:0] LOG_AND_OR  = 3'h3;
   localparam logic [2:0] LOG_OR_AND  = 3'h4;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [2:0] RST_OP_T1 = LOG_AND3;
   localparam logic [2:0] RST_OP_T2 = LOG_AND3;
   localparam logic [2:0] RST_OP_T3 = LOG_DEFAULT;
   localparam logic [3:0] RST_LUT_T1 = 4'h1;
   localparam logic [3:0] RST_LUT_T2 = 4'h2;
   localparam logic [3:0] RST_LUT_T3 = 4'h3;
   localparam logic [1:0] SEL_NONE  = 2'h0;

   // ***************************************************************
   // Carrier types
   // ***************************************************************
   typedef struct packed {
      logic [SRC_TYPE_W-1:0] arg1_type;
      logic [SRC_NUM_W-1:0]  arg1_num;
      logic [SRC_TYPE_W-1:0] arg2_type;
      logic [SRC_NUM_W-1:0]  arg2_num;
      logic [2:0]            rel_op;
   } cts_cond_cfg_t;

   // One source value as seen by the selector
   typedef struct packed {
      logic              err;
      logic [DATA_W-1:0] value;
   } cts_src_t;

   // Lookup table output: valid low means no X-axis source configured
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] value;
   } cts_lut_t;

endpackage

// [verilog/cts_cond_eval.sv]
// One condition evaluator: two argument sources, one relational operator.
// Assumes source values and error flags arrive synchronous to pclk.
`timescale 1ns/1ps
module cts_cond_eval
   import cts_pkg::*;
(
   input  wire cts_cond_cfg_t cfg,
   input  wire cts_src_t      arg1,
   input  wire cts_src_t      arg2,
   output logic [1:0]         result
);

   always_comb begin
      logic hit;
      hit = 1'b0;
      case (cfg.rel_op)
         REL_EQ: hit = (arg1.value == arg2.value);
         REL_NE: hit = (arg1.value != arg2.value);
         REL_GT: hit = (arg1.value >  arg2.value);
         REL_GE: hit = (arg1.value >= arg2.value);
         REL_LT: hit = (arg1.value <  arg2.value);
         REL_LE: hit = (arg1.value <= arg2.value);
         default: hit = 1'b0;
      endcase
      // Unused source takes precedence over an error on the other one
      if (cfg.arg1_type == SRC_NOT_USED || cfg.arg2_type == SRC_NOT_USED) begin
         result = RES_NA;
      end else if (arg1.err || arg2.err) begin
         result = RES_ERROR;
      end else begin
         result = hit ? RES_TRUE : RES_FALSE;
      end
   end

endmodule

// [test/cts_selector_props.sv]
// Checker for the table selector ports: APB timing and output relations.
// Assumes it is bound to every cts_selector instance.
`timescale 1ns/1ps
module cts_selector_props
   import cts_pkg::*;
#(
   parameter int DW = DATA_W
)(
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 clk_en,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire cts_src_t [N_SRC-1:0] src_in,
   input wire cts_lut_t [N_LUT-1:0] lut_in,
   input wire logic [DW-1:0]        sel_out,
   input wire logic                 sel_valid,
   input wire logic [1:0]           sel_table
);
   cts_lut_t [N_LUT-1:0] lut_q_ff;
   logic                 hit;

   // Output lags the tables by one edge, so compare against last cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lut_q_ff <= '0;
      end else if (clk_en) begin
         lut_q_ff <= lut_in;
      end
   end

   always_comb begin
      hit = 1'b0;
      for (int k = 0; k < N_LUT; k++) begin
         hit = hit | (lut_q_ff[k].valid && DW'(lut_q_ff[k].value) == sel_out);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_first_access;
      $rose(penable) && psel && clk_en;
   endsequence
   sequence s_one_wait;
      !pready ##1 pready ##1 !pready;
   endsequence

   AST_APB_WAIT: assert property (s_first_access |-> s_one_wait)
      else $error("apb answer not after one wait state");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   AST_SLVERR_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_SLVERR_NODATA: assert property (pslverr && !pwrite |-> prdata == '0)
      else $error("refused read returned data");
   AST_RESET_IDLE: assert property ($rose(presetn) |->
      sel_table == SEL_NONE && !sel_valid)
      else $error("selector active right after reset");
   AST_VALID_HAS_TABLE: assert property (sel_valid |-> sel_table != 2'h0)
      else $error("output valid with no table selected");
   AST_INVALID_ZERO: assert property (!sel_valid |-> sel_out == '0)
      else $error("output not zero while not available");
   AST_COPY: assert property (sel_valid |-> hit)
      else $error("output is not a copy of any table");
endmodule

bind cts_selector cts_selector_props #(.DW(DW)) u_props (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
   .lut_in(lut_in), .sel_out(sel_out), .sel_valid(sel_valid),
   .sel_table(sel_table));

// [test/cts_consumer.sv]
// Consumer block fed by the selector output.
// Assumes sel_out and sel_valid are registered on pclk.
`timescale 1ns/1ps
module cts_consumer
   import cts_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [DATA_W-1:0] sel_out,
   input  wire logic              sel_valid,
   output logic      [DATA_W-1:0] held_ff
);
   // Keeps last command through not-available, as a driven output would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_ff <= '0;
      end else if (sel_valid) begin
         held_ff <= sel_out;
      end
   end
endmodule

// [test/tb_conditional_table_selector.sv]
// Testbench for the table selector: reset cases, a table of selection
// cases, then error, refusal and not-available cases by hand.
// Assumes the package, checker bind and consumer model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
   miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_conditional_table_selector
   import cts_pkg::*;
;
   typedef struct {
      logic [2:0]  rel;
      logic [2:0]  comb;
      logic [15:0] a;
      logic [15:0] b;
      logic [1:0]  tbl;
   } cts_row_t;
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 clk_en = 1'b1;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [11:0]          paddr = '0;
   logic [31:0]          pwdata = '0;
   logic [31:0]          prdata, rdat;
   logic                 pready, pslverr, rerr, sel_valid;
   logic [1:0]           sel_table;
   logic [DATA_W-1:0]    sel_out, held;
   cts_src_t [N_SRC-1:0] src_in = '0;
   cts_lut_t [N_LUT-1:0] lut_in;
   int                   miscompares = 0;
   int                   comparisons = 0;
   logic [31:0]          rst_cfg [3] = '{32'h11, 32'h21, 32'h30};
   cts_row_t             rows [11] = '{
      '{REL_EQ, LOG_AND3, 16'h5, 16'h5, 2'h1},
      '{REL_NE, LOG_AND3, 16'h5, 16'h5, 2'h2},
      '{REL_GT, LOG_AND3, 16'h6, 16'h5, 2'h1},
      '{REL_GT, LOG_OR3, 16'h5, 16'h5, 2'h2},
      '{REL_GE, LOG_OR3, 16'h5, 16'h5, 2'h1},
      '{REL_LT, LOG_OR3, 16'h4, 16'h5, 2'h1},
      '{REL_LT, LOG_AND_OR, 16'h5, 16'h5, 2'h2},
      '{REL_LE, LOG_AND_OR, 16'h5, 16'h6, 2'h1},
      '{REL_LE, LOG_OR_AND, 16'h6, 16'h5, 2'h2},
      '{REL_EQ, LOG_OR_AND, 16'h5, 16'h5, 2'h1},
      '{REL_NE, LOG_DEFAULT, 16'h5, 16'h5, 2'h1}};

   always #10 pclk = ~pclk;

   cts_selector uut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_in(src_in), .lut_in(lut_in), .sel_out(sel_out),
      .sel_valid(sel_valid), .sel_table(sel_table));
   cts_consumer u_cons (.pclk(pclk), .presetn(presetn), .sel_out(sel_out),
      .sel_valid(sel_valid), .held_ff(held));

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle;
      repeat (2) @(posedge pclk);
   endtask

   // Arguments from slots 4 and 5, operator in bits 18:16
   function automatic logic [31:0] cw(input logic [2:0] op);
      return {13'h0, op, 16'h1101};
   endfunction

   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      give_verdict();
   end

   initial begin
      for (int k = 0; k < N_LUT; k++) begin
         lut_in[k] = {1'b1, 16'h1000 + 16'(k)};
      end
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      `CHK(sel_table, SEL_NONE)
      apb(1'b0, OFS_CTRL, '0);
      `CHK(rdat, 32'h0)
      for (int t = 0; t < 3; t++) begin
         apb(1'b0, 12'(OFS_TBL_CFG + 4*t), '0);
         `CHK(rdat, rst_cfg[t])
      end
      apb(1'b1, OFS_CTRL, 32'h1);
      settle();
      `CHK(sel_out, 16'h1001)
      apb(1'b0, OFS_COND, '0);
      `CHK(rdat, 32'h0030_0000)
      `CHK(held, 16'h1001)
      $display("reset and enable done");
      foreach (rows[i]) begin
         src_in[4].value <= rows[i].a;
         src_in[5].value <= rows[i].b;
         apb(1'b1, OFS_COND, cw(rows[i].rel));
         apb(1'b1, 12'(OFS_COND + 8), cw(rows[i].rel));
         apb(1'b1, OFS_TBL_CFG, {28'h1, 1'b0, rows[i].comb});
         settle();
         `CHK(sel_table, rows[i].tbl)
         `CHK(sel_out, 16'h1000 + 16'(rows[i].tbl))
      end
      $display("selection table done");
      src_in[4] <= {1'b1, 16'h5};
      apb(1'b1, OFS_COND, cw(REL_EQ));
      apb(1'b1, 12'(OFS_COND + 8), cw(REL_EQ));
      apb(1'b1, OFS_TBL_CFG, 32'h11);
      settle();
      `CHK(sel_table, 2'h2)
      apb(1'b0, OFS_COND, '0);
      `CHK(rdat[21:20], RES_ERROR)
      apb(1'b1, 12'(OFS_COND + 4), {13'h0, REL_GT, 16'h0001});
      apb(1'b0, 12'(OFS_COND + 4), '0);
      `CHK(rdat, 32'h0030_0001)
      $display("error and operator lock done");
      src_in[4] <= {1'b0, 16'h5};
      src_in[5].value <= 16'h6;
      apb(1'b1, OFS_TBL_CFG, 32'h12);
      apb(1'b1, 12'(OFS_TBL_CFG + 4), 32'h22);
      apb(1'b1, 12'(OFS_TBL_CFG + 8), 32'h90);
      settle();
      `CHK(sel_table, 2'h3)
      `CHK(sel_out, 16'h1009)
      lut_in[9].valid <= 1'b0;
      settle();
      `CHK({sel_table, sel_valid}, 3'h6)
      apb(1'b1, 12'(OFS_TBL_CFG + 8), 32'hc2);
      apb(1'b0, 12'(OFS_TBL_CFG + 8), '0);
      `CHK(rdat, 32'h92)
      lut_in[9].valid <= 1'b1;
      settle();
      `CHK({sel_table, sel_valid}, 3'h0)
      $display("fall through cases done");
      apb(1'b0, 12'h0fc, '0);
      `CHK({rerr, rdat}, 33'h1_0000_0000)
      apb(1'b1, 12'(OFS_TBL_CFG + 8), 32'h90);
      settle();
      `CHK(sel_table, 2'h3)
      clk_en <= 1'b0;
      lut_in[9].value <= 16'h2222;
      settle();
      `CHK(sel_out, 16'h1009)
      clk_en <= 1'b1;
      settle();
      `CHK(sel_out, 16'h2222)
      lut_in[9].value <= 16'h1009;
      settle();
      apb(1'b1, OFS_CTRL, 32'h0);
      settle();
      `CHK({sel_table, sel_valid}, 3'h0)
      $display("refusal and disable done");
      give_verdict();
   end
endmodule
